/* verilog/otgtr_pkg.sv */
// Purpose: constants and types for the otg timer and rise-enable block
// Assumes: 16-bit local register bus, byte addresses as printed
// Notes: one package shared by the block and the bench
package otgtr_pkg;
  localparam logic [15:0] ADDR_RISE_SET = 16'h0384;
  localparam logic [15:0] ADDR_RISE_CLR = 16'h0386;
  localparam logic [15:0] ADDR_TMR_LO_SET = 16'h0388;
  localparam logic [15:0] ADDR_TMR_LO_CLR = 16'h038a;
  localparam logic [15:0] ADDR_TMR_HI_SET = 16'h038c;
  localparam logic [15:0] ADDR_TMR_HI_CLR = 16'h038e;
  localparam logic [15:0] RISE_RESET = 16'h0000;
  localparam logic [15:0] RISE_WR_MASK = 16'h03ff;
  localparam logic [15:0] TMR_LO_RESET = 16'h0000;
  localparam logic [15:0] TMR_HI_RESET = 16'h0000;
  localparam logic [15:0] TMR_HI_WR_MASK = 16'h80ff;
  localparam int RUN_BIT_HI = 15;
  localparam int NUM_EVENTS = 10;
  localparam int EV_TIMEOUT = 9;
  localparam int EV_SE0_IDLE = 8;
  localparam int EV_SESS_END = 7;
  localparam int EV_B_DISCONNECT_A_CONNECT = 6;
  localparam int EV_RESUME = 5;
  localparam int EV_REMOTE_CONN = 4;
  localparam int EV_CONN_TYPE = 3;
  localparam int EV_DPLUS_PULSE_IN_SESSION_REQUEST = 2;
  localparam int EV_SESS_VLD = 1;
  localparam int EV_BUS_VLD = 0;
  // tick period and clock period in ns
  localparam int TICK_NS = 10000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 9;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {
    OTGTR_IDLE = 2'b00,
    OTGTR_RUN = 2'b01,
    OTGTR_DONE = 2'b11
  } otgtr_state_t;

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } otgtr_bus_req_t;

  typedef struct packed {
    logic b_idle_long_se0;
    logic b_session_ended;
    logic b_disconnect_a_connect;
    logic port_resume_seen;
    logic remote_connect_seen;
    logic connector_type_pin;
    logic dplus_pulse_in_session_request;
    logic session_valid;
    logic bus_supply_valid;
  } otgtr_status_t;
endpackage : otgtr_pkg

/* verilog/otgtr_top.sv */
// Purpose: otg timer and rising-edge interrupt enable mask
// Assumes: synchronous status inputs and bus strobes on CLK
// Notes: RISE_EVENT pulses feed the interrupt latch elsewhere
module otgtr_top
  import otgtr_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire otgtr_pkg::otgtr_bus_req_t BUS_REQ,
  input wire otgtr_pkg::otgtr_status_t OTG_STATUS,
  output logic [15:0] BUS_RDATA,
  output logic BUS_RVALID,
  output logic [otgtr_pkg::NUM_EVENTS-1:0] RISE_EVENT,
  output logic SESSION_TIMER_EXPIRED,
  output logic TIMER_RUNNING
);
  import otgtr_pkg::*;

  logic [15:0] rise_en_reg;
  logic [15:0] tmr_lo_reg;
  logic [15:0] tmr_hi_reg;
  logic [23:0] count_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  otgtr_state_t state_reg;
  logic [NUM_EVENTS-2:0] status_prev_reg;
  logic [NUM_EVENTS-2:0] status_now;
  logic expired_pulse;
  logic wr_rise_set;
  logic wr_rise_clr;
  logic wr_lo_set;
  logic wr_lo_clr;
  logic wr_hi_set;
  logic wr_hi_clr;
  logic run_start;
  logic run_stop;
  logic [23:0] timer_preload;
  logic tick;

  // write strobe decode
  always_comb
  begin
    wr_rise_set = 1'b0;
    wr_rise_clr = 1'b0;
    wr_lo_set = 1'b0;
    wr_lo_clr = 1'b0;
    wr_hi_set = 1'b0;
    wr_hi_clr = 1'b0;
    if (BUS_REQ.cs && BUS_REQ.wr)
    begin
      if (BUS_REQ.addr == ADDR_RISE_SET)
        wr_rise_set = 1'b1;
      else if (BUS_REQ.addr == ADDR_RISE_CLR)
        wr_rise_clr = 1'b1;
      else if (BUS_REQ.addr == ADDR_TMR_LO_SET)
        wr_lo_set = 1'b1;
      else if (BUS_REQ.addr == ADDR_TMR_LO_CLR)
        wr_lo_clr = 1'b1;
      else if (BUS_REQ.addr == ADDR_TMR_HI_SET)
        wr_hi_set = 1'b1;
      else if (BUS_REQ.addr == ADDR_TMR_HI_CLR)
        wr_hi_clr = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rise_en_reg <= RISE_RESET;
    else if (CLK_EN)
    begin
      // reserved bits kept at zero even if software slips
      if (wr_rise_set)
        rise_en_reg <= rise_en_reg | (BUS_REQ.wdata & RISE_WR_MASK);
      else if (wr_rise_clr)
        rise_en_reg <= rise_en_reg & ~BUS_REQ.wdata;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      tmr_lo_reg <= TMR_LO_RESET;
    else if (CLK_EN)
    begin
      if (wr_lo_set)
        tmr_lo_reg <= tmr_lo_reg | BUS_REQ.wdata;
      else if (wr_lo_clr)
        tmr_lo_reg <= tmr_lo_reg & ~BUS_REQ.wdata;
    end
  end

  assign run_start = wr_hi_set && BUS_REQ.wdata[RUN_BIT_HI] && !tmr_hi_reg[RUN_BIT_HI];
  assign run_stop = wr_hi_clr && BUS_REQ.wdata[RUN_BIT_HI];

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      tmr_hi_reg <= TMR_HI_RESET;
    else if (CLK_EN)
    begin
      if (wr_hi_set)
        tmr_hi_reg <= tmr_hi_reg | (BUS_REQ.wdata & TMR_HI_WR_MASK);
      else if (wr_hi_clr)
        tmr_hi_reg <= tmr_hi_reg & ~BUS_REQ.wdata;
      // self clear on expiry
      // applied last so a same-cycle write cannot leave run set with no timer behind it
      if (expired_pulse)
        tmr_hi_reg[RUN_BIT_HI] <= 1'b0;
    end
  end

  assign timer_preload = {tmr_hi_reg[7:0], tmr_lo_reg};
  assign tick = (prescale_reg == PRESCALE_LAST);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      prescale_reg <= '0;
    else if (CLK_EN)
    begin
      if (state_reg != OTGTR_RUN || tick)
        prescale_reg <= '0;
      else
        prescale_reg <= prescale_reg + 1'b1;
    end
  end

  // timer state machine
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg <= OTGTR_IDLE;
      count_reg <= '0;
    end
    else if (CLK_EN)
    begin
      case (state_reg)
        OTGTR_IDLE:
        begin
          if (run_start)
          begin
            state_reg <= OTGTR_RUN;
            count_reg <= {timer_preload[23:16] | BUS_REQ.wdata[7:0], timer_preload[15:0]};
          end
        end
        OTGTR_RUN:
        begin
          if (run_stop)
            state_reg <= OTGTR_IDLE;
          else if (count_reg == 24'h000000)
            state_reg <= OTGTR_DONE;
          else if (tick)
          begin
            count_reg <= count_reg - 1'b1;
            if (count_reg == 24'h000001)
              state_reg <= OTGTR_DONE;
          end
        end
        OTGTR_DONE:
          state_reg <= OTGTR_IDLE;
        default:
          state_reg <= OTGTR_IDLE;
      endcase
    end
  end

  assign expired_pulse = (state_reg == OTGTR_DONE);
  assign SESSION_TIMER_EXPIRED = expired_pulse && CLK_EN;
  assign TIMER_RUNNING = tmr_hi_reg[RUN_BIT_HI];

  assign status_now = {
    OTG_STATUS.b_idle_long_se0,
    OTG_STATUS.b_session_ended,
    OTG_STATUS.b_disconnect_a_connect,
    OTG_STATUS.port_resume_seen,
    OTG_STATUS.remote_connect_seen,
    OTG_STATUS.connector_type_pin,
    OTG_STATUS.dplus_pulse_in_session_request,
    OTG_STATUS.session_valid,
    OTG_STATUS.bus_supply_valid
  };

  // previous status for edge detect
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      status_prev_reg <= '0;
    else if (CLK_EN)
      status_prev_reg <= status_now;
  end

  // bit positions
  // the fall side is elsewhere; a rise is only forwarded when enabled here
  always_comb
  begin
    RISE_EVENT = {expired_pulse, status_now & ~status_prev_reg} &
      rise_en_reg[NUM_EVENTS-1:0];
    if (!CLK_EN)
      RISE_EVENT = '0;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      BUS_RDATA <= 16'h0000;
      BUS_RVALID <= 1'b0;
    end
    else if (CLK_EN)
    begin
      BUS_RVALID <= BUS_REQ.cs && BUS_REQ.rd;
      if (BUS_REQ.cs && BUS_REQ.rd)
      begin
        if (BUS_REQ.addr == ADDR_RISE_SET || BUS_REQ.addr == ADDR_RISE_CLR)
          BUS_RDATA <= rise_en_reg;
        else if (BUS_REQ.addr == ADDR_TMR_LO_SET || BUS_REQ.addr == ADDR_TMR_LO_CLR)
          BUS_RDATA <= tmr_lo_reg;
        else if (BUS_REQ.addr == ADDR_TMR_HI_SET || BUS_REQ.addr == ADDR_TMR_HI_CLR)
          BUS_RDATA <= tmr_hi_reg;
        else
          BUS_RDATA <= 16'h0000;
      end
    end
  end
endmodule : otgtr_top

/* verification/otgtr_top_props.sv */
// Purpose: port checks for otgtr_top
// Assumes: one CLK domain, ARST_N async low
// Notes: bound to every otgtr_top instance
module otgtr_top_props
  import otgtr_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire otgtr_pkg::otgtr_bus_req_t BUS_REQ,
  input wire otgtr_pkg::otgtr_status_t OTG_STATUS,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_RVALID,
  input wire logic [otgtr_pkg::NUM_EVENTS-1:0] RISE_EVENT,
  input wire logic SESSION_TIMER_EXPIRED,
  input wire logic TIMER_RUNNING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire rd_t = CLK_EN & BUS_REQ.cs & BUS_REQ.rd;
  wire wr_t = CLK_EN & BUS_REQ.cs & BUS_REQ.wr & BUS_REQ.wdata[15];
  wire hi_set = wr_t & (BUS_REQ.addr == ADDR_TMR_HI_SET);
  wire hi_clr = wr_t & (BUS_REQ.addr == ADDR_TMR_HI_CLR);
  AST_RD_ANS: assert property (rd_t |=> BUS_RVALID)
    else $error("read got no answer");
  AST_RV_CAUSE: assert property (BUS_RVALID |-> $past(rd_t))
    else $error("answer without read");
  AST_START: assert property (hi_set && !TIMER_RUNNING |=> TIMER_RUNNING)
    else $error("timer did not start");
  AST_STOP: assert property (hi_clr |=> !TIMER_RUNNING)
    else $error("timer did not stop");
  AST_EXP_RUN: assert property (SESSION_TIMER_EXPIRED |-> TIMER_RUNNING ##1 (!TIMER_RUNNING && !SESSION_TIMER_EXPIRED))
    else $error("expiry pulse or self-clear wrong");
  AST_EV9: assert property (RISE_EVENT[9] |-> SESSION_TIMER_EXPIRED)
    else $error("timer event without expiry");
  // an event needs its input high now or just before
  AST_EV_CAUSE: assert property ((RISE_EVENT[8:0] & ~(OTG_STATUS | $past(OTG_STATUS))) == 9'h000)
    else $error("event without rising input");
  AST_PULSE: assert property ((RISE_EVENT & $past(RISE_EVENT)) == 10'h000)
    else $error("event held past one cycle");
endmodule : otgtr_top_props

bind otgtr_top otgtr_top_props u_props (.CLK(CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
  .BUS_REQ(BUS_REQ), .OTG_STATUS(OTG_STATUS), .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID),
  .RISE_EVENT(RISE_EVENT), .SESSION_TIMER_EXPIRED(SESSION_TIMER_EXPIRED),
  .TIMER_RUNNING(TIMER_RUNNING));

/* verification/test_otg_timer_and_rise_irq_enable.sv */
// Purpose: self-checking bench for otgtr_top
// Assumes: CLK_EN held high, inputs driven 2 ns after CLK rises
// Notes: timer preload 3 gives 1200 edges from the start write to expiry
module test_otg_timer_and_rise_irq_enable
  import otgtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  otgtr_bus_req_t req = '0;
  otgtr_status_t st = '0;
  logic [15:0] rdata;
  logic [15:0] q;
  logic rvalid;
  logic expired;
  logic running;
  logic [9:0] ev;
  int fails = 0;
  int checked = 0;
  int n;
  always #12.5 clk = ~clk;
  otgtr_top u_dut (.CLK(clk), .ARST_N(arst_n), .CLK_EN(1'b1), .BUS_REQ(req), .OTG_STATUS(st),
    .BUS_RDATA(rdata), .BUS_RVALID(rvalid), .RISE_EVENT(ev), .SESSION_TIMER_EXPIRED(expired),
    .TIMER_RUNNING(running));
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // request held through the taking edge, released 2 ns after it
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #2 req = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #2 req = '0;
    q = rdata;
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    cmp("rvalid", 16'h0001, {15'h0000, rvalid});
    cmp("rdata", exp, q);
  endtask : rd
  // events may come combinationally or one cycle late, so two cycles are gathered
  task automatic rise(input logic [15:0] m, input logic [15:0] exp);
    logic [9:0] seen;
    bus(1'b1, ADDR_RISE_CLR, RISE_WR_MASK);
    bus(1'b1, ADDR_RISE_SET, m);
    @(posedge clk);
    #2 st = '1;
    #10 seen = ev;
    @(posedge clk);
    #10 seen |= ev;
    @(posedge clk);
    #2 st = '0;
    cmp("rise", exp, {7'h00, seen[8:0]});
  endtask : rise
  task automatic timer_expire;
    bus(1'b1, ADDR_TMR_LO_SET, 16'h0003);
    bus(1'b1, ADDR_TMR_HI_SET, 16'h8000);
    cmp("running", 16'h0001, {15'h0000, running});
    n = 0;
    while (expired !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #2 n++;
    end
    cmp("ticks", 16'h04b0, 16'(n));
    cmp("ev9", 16'h0001, {15'h0000, ev[9]});
    @(posedge clk);
    #2 cmp("running", 16'h0000, {15'h0000, running});
    rd(ADDR_TMR_HI_CLR, 16'h0000);
    rd(ADDR_TMR_LO_CLR, 16'h0003);
  endtask : timer_expire
  task automatic timer_stop;
    bus(1'b1, ADDR_TMR_HI_SET, 16'h8000);
    repeat (10) @(posedge clk);
    bus(1'b1, ADDR_TMR_HI_CLR, 16'h8000);
    cmp("running", 16'h0000, {15'h0000, running});
    n = 0;
    repeat (1300)
    begin
      @(posedge clk);
      #2 n += expired;
    end
    cmp("late", 16'h0000, 16'(n));
  endtask : timer_stop
  initial
  begin
    repeat (10) @(posedge clk);
    #2 arst_n = 1'b1;
    for (int i = 0; i < 6; i++)
      rd(ADDR_RISE_SET + 16'(2 * i), 16'h0000);
    rd(16'h0390, 16'h0000);
    bus(1'b1, ADDR_RISE_SET, RISE_WR_MASK);
    rd(ADDR_RISE_CLR, 16'h03ff);
    bus(1'b1, ADDR_RISE_CLR, 16'h0155);
    rd(ADDR_RISE_SET, 16'h02aa);
    rise(16'h02aa, 16'h00aa);
    rise(RISE_WR_MASK, 16'h01ff);
    timer_expire();
    timer_stop();
    wrap_up();
  end
  initial
  begin
    #(25 * 10000);
    fails++;
    wrap_up();
  end
endmodule : test_otg_timer_and_rise_irq_enable
